// *** osc_cmd_pkg.sv ***
// constants for the oscillator two-wire command port
package osc_cmd_pkg;
  localparam logic [3:0] TYPE_CODE     = 4'hA;   // arbitrary device-type code
  localparam logic [7:0] CMD_DIVIDER   = 8'h01;
  localparam logic [7:0] CMD_MUX       = 8'h02;
  localparam logic [7:0] CMD_ADDR_CFG  = 8'h0D;
  localparam logic [7:0] CMD_COMMIT_NV = 8'h3F;
  localparam int         WC_BIT        = 3;
  localparam logic [15:0] DIV_RESET    = 16'h0000;
  localparam logic [15:0] MUX_RESET    = 16'h0000;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam int          NV_WRITE_US  = 10;
  localparam int          CLOCK_MHZ    = 125;
  localparam int          NV_WRITE_CYC = NV_WRITE_US * CLOCK_MHZ;
endpackage

// *** oscillator_serial_command_port.sv ***
// two-wire slave command port with nonvolatile commit control
// Functional notes
// - The first byte after a start is a control byte whose upper four bits hold the type code.
// - The next three control bits are the device select bits, the low address bits.
// - The last control bit chooses read when one and write when zero.
// - The device acknowledges only when type code and select bits both match.
// - A write sends address, then a command byte that is acknowledged, then data bytes.
// - Command 01 writes or reads the divider register.
// - Command 02 writes or reads the output mux register.
// - Command 0D writes or reads the address configuration register.
// - With write control set, command 3F copies all three registers to nonvolatile memory.
// - With write control clear, contents are committed at the end of each command.
// - A write to the address configuration register commits at once, whatever write control.
// - During a nonvolatile write every request is answered with not-acknowledge.
// - The divider value is ten bits sent first byte high, second byte low six bits unused.
// - In the configuration byte bits 7..4 are zero, bit 3 is write control, bits 2..0 select.
// - In power-down the registers cannot be programmed.
`timescale 1ns/1ns
module oscillator_serial_command_port #(
  parameter int NvWriteCycles = osc_cmd_pkg::NV_WRITE_CYC
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // two-wire pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // device state
  input  wire logic        powerDown,
  output logic [15:0]      dividerSetting,
  output logic [15:0]      outputMuxSetting,
  output logic [7:0]       addressConfig,
  output logic             nvWriteBusy,
  output logic             nvCommitPulse
);
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_ADDR = 5'h02, S_CMD = 5'h04, S_WDATA = 5'h08, S_RDATA = 5'h10
  } phase_e;

  typedef struct packed {
    logic [1:0]  sclSync;
    logic [1:0]  sdaSync;
    logic        sclPrev;
    logic        sdaPrev;
    phase_e      phase;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic        ackSlot;
    logic        ackDrive;
    logic        rdBit;
    logic        mstNack;
    logic [7:0]  cmd;
    logic        byteIdx;
    logic        dirty;
    logic [15:0] divReg;
    logic [15:0] muxReg;
    logic [7:0]  cfgReg;
    logic [15:0] nvCnt;
    logic        commit;
  } state_s;

  state_s cur_q, nxt_d;

  logic sclRise, sclFall, startCond, stopCond, addrMatch, wc;
  logic [7:0] rdByte;
  logic [7:0] rxByte;

  assign sclRise   = cur_q.sclSync[1] & ~cur_q.sclPrev;
  assign sclFall   = ~cur_q.sclSync[1] & cur_q.sclPrev;
  assign startCond = cur_q.sclSync[1] & cur_q.sclPrev & cur_q.sdaPrev & ~cur_q.sdaSync[1];
  assign stopCond  = cur_q.sclSync[1] & cur_q.sclPrev & ~cur_q.sdaPrev & cur_q.sdaSync[1];
  assign rxByte    = {cur_q.shift[6:0], cur_q.sdaSync[1]};
  assign wc        = cur_q.cfgReg[osc_cmd_pkg::WC_BIT];
  // type code in the top nibble, select bits from the configuration register
  assign addrMatch = (cur_q.shift[7:4] == osc_cmd_pkg::TYPE_CODE)
                   && (cur_q.shift[3:1] == cur_q.cfgReg[2:0]);

  always_comb begin
    unique case (cur_q.cmd)
      osc_cmd_pkg::CMD_DIVIDER:  rdByte = cur_q.byteIdx ? cur_q.divReg[7:0] : cur_q.divReg[15:8];
      osc_cmd_pkg::CMD_MUX:      rdByte = cur_q.byteIdx ? cur_q.muxReg[7:0] : cur_q.muxReg[15:8];
      osc_cmd_pkg::CMD_ADDR_CFG: rdByte = cur_q.cfgReg;
      default:                   rdByte = 8'hFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_d = cur_q;
    nxt_d.sclSync = {cur_q.sclSync[0], sclIn};
    nxt_d.sdaSync = {cur_q.sdaSync[0], sdaIn};
    nxt_d.sclPrev = cur_q.sclSync[1];
    nxt_d.sdaPrev = cur_q.sdaSync[1];
    nxt_d.commit  = 1'b0;
    // one counter is the only busy source, so a commit during a commit just restarts it
    if (cur_q.nvCnt != 16'h0000) begin
      nxt_d.nvCnt = cur_q.nvCnt - 16'h0001;
    end
    if (startCond) begin
      // a repeated start keeps the command so a read can follow it
      if (cur_q.dirty && !wc && cur_q.phase == S_WDATA) begin
        nxt_d.commit = 1'b1;
        nxt_d.dirty  = 1'b0;
      end
      nxt_d.phase    = S_ADDR;
      nxt_d.bitCnt   = 4'h0;
      nxt_d.ackSlot  = 1'b0;
      nxt_d.ackDrive = 1'b0;
      nxt_d.rdBit    = 1'b0;
      nxt_d.byteIdx  = 1'b0;
    end else if (stopCond) begin
      if (cur_q.dirty && !wc) begin
        nxt_d.commit = 1'b1;
      end
      nxt_d.dirty    = 1'b0;
      nxt_d.phase    = S_IDLE;
      nxt_d.ackDrive = 1'b0;
      nxt_d.rdBit    = 1'b0;
    end else if (cur_q.phase != S_IDLE) begin
      if (sclRise && !cur_q.ackSlot) begin
        nxt_d.shift  = rxByte;
        nxt_d.bitCnt = cur_q.bitCnt + 4'h1;
      end else if (sclRise && cur_q.ackSlot && cur_q.phase == S_RDATA) begin
        nxt_d.mstNack = cur_q.sdaSync[1];
      end
      if (sclFall) begin
        if (cur_q.ackSlot) begin
          nxt_d.ackSlot  = 1'b0;
          nxt_d.ackDrive = 1'b0;
          nxt_d.bitCnt   = 4'h0;
          if (cur_q.phase == S_RDATA) begin
            if (cur_q.mstNack) begin
              nxt_d.phase = S_IDLE;
              nxt_d.rdBit = 1'b0;
            end else begin
              nxt_d.byteIdx = ~cur_q.byteIdx;
              nxt_d.shift   = rdByte;
              nxt_d.rdBit   = rdByte[7];
            end
          end
        end else if (cur_q.bitCnt == 4'h8) begin
          nxt_d.ackSlot = 1'b1;
          nxt_d.rdBit   = 1'b0;
          unique case (cur_q.phase)
            S_ADDR: begin
              // no address is acknowledged while the nonvolatile write runs
              if (addrMatch && cur_q.nvCnt == 16'h0000) begin
                nxt_d.ackDrive = 1'b1;
                if (cur_q.shift[0]) begin
                  nxt_d.phase = S_RDATA;
                  nxt_d.shift = rdByte;
                end else begin
                  nxt_d.phase = S_CMD;
                end
              end else begin
                nxt_d.phase = S_IDLE;
              end
            end
            S_CMD: begin
              nxt_d.ackDrive = 1'b1;
              nxt_d.cmd      = cur_q.shift;
              nxt_d.byteIdx  = 1'b0;
              nxt_d.phase    = S_WDATA;
              if (cur_q.shift == osc_cmd_pkg::CMD_COMMIT_NV && wc && !powerDown) begin
                nxt_d.commit = 1'b1;
              end
            end
            S_WDATA: begin
              nxt_d.ackDrive = 1'b1;
              nxt_d.byteIdx  = ~cur_q.byteIdx;
              if (!powerDown) begin
                unique case (cur_q.cmd)
                  osc_cmd_pkg::CMD_DIVIDER: begin
                    // ten bits left-justified over two bytes
                    if (cur_q.byteIdx) nxt_d.divReg[7:0] = {cur_q.shift[7:6], 6'h00};
                    else               nxt_d.divReg[15:8] = cur_q.shift;
                    nxt_d.dirty = 1'b1;
                  end
                  osc_cmd_pkg::CMD_MUX: begin
                    if (cur_q.byteIdx) nxt_d.muxReg[7:0] = cur_q.shift;
                    else               nxt_d.muxReg[15:8] = cur_q.shift;
                    nxt_d.dirty = 1'b1;
                  end
                  osc_cmd_pkg::CMD_ADDR_CFG: begin
                    nxt_d.cfgReg = {4'h0, cur_q.shift[3:0]};
                    nxt_d.commit = 1'b1;
                    nxt_d.dirty  = 1'b0;
                  end
                  default: ;
                endcase
              end
            end
            S_RDATA: nxt_d.ackDrive = 1'b0; // the master acknowledges read bytes
            default: nxt_d.phase = S_IDLE;
          endcase
        end else if (cur_q.phase == S_RDATA) begin
          nxt_d.rdBit = cur_q.shift[7]; // bits already sent have shifted out of the top
        end
      end
    end
    if (nxt_d.commit) begin
      nxt_d.nvCnt = NvWriteCycles[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur_q <= '{sclSync: 2'b11, sdaSync: 2'b11, sclPrev: 1'b1, sdaPrev: 1'b1,
                 phase: S_IDLE, bitCnt: 4'h0, shift: 8'h00, ackSlot: 1'b0,
                 ackDrive: 1'b0, rdBit: 1'b0, mstNack: 1'b0, cmd: 8'h00,
                 byteIdx: 1'b0, dirty: 1'b0, divReg: osc_cmd_pkg::DIV_RESET,
                 muxReg: osc_cmd_pkg::MUX_RESET, cfgReg: osc_cmd_pkg::CFG_RESET,
                 nvCnt: 16'h0000, commit: 1'b0};
    end else begin
      cur_q <= nxt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // open drain: only ever pull low
  assign sdaOut           = 1'b0;
  // the first read bit must be driven as soon as the ack slot ends, not one bit late
  assign sdaOe            = cur_q.ackDrive | (cur_q.phase == S_RDATA && !cur_q.ackSlot
                                              && !cur_q.rdBit);
  assign dividerSetting   = cur_q.divReg;
  assign outputMuxSetting = cur_q.muxReg;
  assign addressConfig    = cur_q.cfgReg;
  assign nvWriteBusy      = (cur_q.nvCnt != 16'h0000);
  assign nvCommitPulse    = cur_q.commit;

  ////////////////////////////////////////////////////////////////////////////////
  a_busy_no_ack: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_ADDR && sclFall && cur_q.bitCnt == 4'h8 && nvWriteBusy)
    |=> !cur_q.ackDrive) else $error("ack given during nonvolatile write");
  a_cfg_commit_now: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_WDATA && sclFall && !cur_q.ackSlot && cur_q.bitCnt == 4'h8
     && cur_q.cmd == osc_cmd_pkg::CMD_ADDR_CFG && !powerDown)
    |=> nvCommitPulse ##1 nvWriteBusy) else $error("config write not committed");
  a_cfg_reserved_zero: assert property (@(posedge clock) disable iff (sys_rst)
    addressConfig[7:4] == 4'h0) else $error("reserved config bits set");
  a_div_low_zero: assert property (@(posedge clock) disable iff (sys_rst)
    dividerSetting[5:0] == 6'h00) else $error("unused divider bits set");
  a_pdn_no_prog: assert property (@(posedge clock) disable iff (sys_rst)
    powerDown && $past(powerDown) |-> $stable(dividerSetting) && $stable(outputMuxSetting)
    && $stable(addressConfig)) else $error("register changed in power-down");
  a_mismatch_no_ack: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_ADDR && sclFall && cur_q.bitCnt == 4'h8 && !addrMatch)
    |=> !cur_q.ackDrive && cur_q.phase == S_IDLE) else $error("ack on foreign address");
  a_stop_autocommit: assert property (@(posedge clock) disable iff (sys_rst)
    (stopCond && cur_q.dirty && !wc) |=> nvCommitPulse) else $error("no commit at stop");
  a_commit_wc_gated: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_CMD && sclFall && cur_q.bitCnt == 4'h8 && !startCond && !stopCond
     && cur_q.shift == osc_cmd_pkg::CMD_COMMIT_NV && wc && !powerDown)
    |=> nvCommitPulse) else $error("commit command ignored");

  ////////////////////////////////////////////////////////////////////////////////
  // protocol decode, register storage and commit gating
  a_read_goes_rdata: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_ADDR && sclFall && cur_q.bitCnt == 4'h8 && addrMatch && !nvWriteBusy
     && cur_q.shift[0])
    |=> cur_q.phase == S_RDATA && cur_q.ackDrive) else $error("read direction not taken");
  a_write_goes_cmd: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_ADDR && sclFall && cur_q.bitCnt == 4'h8 && addrMatch && !nvWriteBusy
     && !cur_q.shift[0])
    |=> cur_q.phase == S_CMD && cur_q.ackDrive) else $error("write direction not taken");
  a_cmd_acked: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_CMD && sclFall && !cur_q.ackSlot && cur_q.bitCnt == 4'h8)
    |=> cur_q.ackDrive && cur_q.phase == S_WDATA) else $error("command byte not acknowledged");
  a_div_high_store: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_WDATA && sclFall && !cur_q.ackSlot && cur_q.bitCnt == 4'h8 && !powerDown
     && cur_q.cmd == osc_cmd_pkg::CMD_DIVIDER && !cur_q.byteIdx)
    |=> dividerSetting[15:8] == $past(cur_q.shift)) else $error("divider high byte lost");
  a_div_low_store: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_WDATA && sclFall && !cur_q.ackSlot && cur_q.bitCnt == 4'h8 && !powerDown
     && cur_q.cmd == osc_cmd_pkg::CMD_DIVIDER && cur_q.byteIdx)
    |=> dividerSetting[7:6] == $past(cur_q.shift[7:6])) else $error("divider low bits lost");
  a_mux_low_store: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_WDATA && sclFall && !cur_q.ackSlot && cur_q.bitCnt == 4'h8 && !powerDown
     && cur_q.cmd == osc_cmd_pkg::CMD_MUX && cur_q.byteIdx)
    |=> outputMuxSetting[7:0] == $past(cur_q.shift)) else $error("mux low byte lost");
  a_cfg_store: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_WDATA && sclFall && !cur_q.ackSlot && cur_q.bitCnt == 4'h8 && !powerDown
     && cur_q.cmd == osc_cmd_pkg::CMD_ADDR_CFG)
    |=> addressConfig[3:0] == $past(cur_q.shift[3:0])) else $error("config byte lost");
  a_undef_no_change: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_WDATA && sclFall && !cur_q.ackSlot && cur_q.bitCnt == 4'h8
     && cur_q.cmd != osc_cmd_pkg::CMD_DIVIDER && cur_q.cmd != osc_cmd_pkg::CMD_MUX
     && cur_q.cmd != osc_cmd_pkg::CMD_ADDR_CFG)
    |=> $stable(dividerSetting) && $stable(outputMuxSetting) && $stable(addressConfig)
    && !nvCommitPulse) else $error("undefined command changed state");
  a_wc_no_autocommit: assert property (@(posedge clock) disable iff (sys_rst)
    (stopCond && wc) |=> !nvCommitPulse) else $error("auto commit with write control set");
  a_pdn_no_commit: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_CMD && sclFall && !cur_q.ackSlot && cur_q.bitCnt == 4'h8 && powerDown
     && cur_q.shift == osc_cmd_pkg::CMD_COMMIT_NV) |=> !nvCommitPulse)
    else $error("commit taken in power-down");
  a_read_nack_idle: assert property (@(posedge clock) disable iff (sys_rst)
    (cur_q.phase == S_RDATA && sclFall && cur_q.ackSlot && cur_q.mstNack)
    |=> cur_q.phase == S_IDLE && !sdaOe) else $error("read not ended by master nack");
  // sda may only move while scl is low, otherwise the master would see a start or stop
  a_sda_edge_only: assert property (@(posedge clock) disable iff (sys_rst)
    $changed(sdaOe) |-> $past(sclFall) || $past(startCond) || $past(stopCond))
    else $error("sda moved while scl high");
  a_busy_on_commit: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(nvWriteBusy) |-> nvCommitPulse) else $error("busy without commit");
endmodule // oscillator_serial_command_port

// *** osc_bus_master.sv ***
// two-wire bus master model that drives the command port
`timescale 1ns/1ns
module osc_bus_master (
  // clock and bus
  input  wire logic       clock,
  input  wire logic       sdaWire,
  output logic            sclOut,
  output logic            sdaPull,
  // observed acknowledge bits and read bytes
  output logic            gotStrobe,
  output logic [7:0]      gotByte
);
  ////////////////////////////////////////
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
    gotStrobe = 1'b0;
    gotByte = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // data only moves while scl is low, so it never mimics start or stop
  task automatic bitx(input logic b, output logic s);
    sclOut <= 1'b0;
    tick(1);
    sdaPull <= ~b;
    tick(3);
    sclOut <= 1'b1;
    tick(4);
    s = sdaWire;
  endtask
  task automatic report(input logic [7:0] v);
    gotByte <= v;
    gotStrobe <= 1'b1;
    tick(1);
    gotStrobe <= 1'b0;
  endtask
  // scl stays high between frames; a repeated start first adds a released pulse
  task automatic start(input logic rep);
    logic s;
    if (rep) begin
      bitx(1'b1, s);
    end
    sdaPull <= 1'b1;
    tick(4);
  endtask
  task automatic stop();
    logic s;
    bitx(1'b0, s);
    sdaPull <= 1'b0;
    tick(8);
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], s);
    end
    bitx(1'b1, s);
    report({7'h00, s});
  endtask
  task automatic rbyte(input logic nack);
    logic s;
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, s);
      v = {v[6:0], s};
    end
    report(v);
    bitx(nack, s);
  endtask
endmodule // osc_bus_master

// *** test_oscillator_serial_command_port.sv ***
// self-checking bench for the oscillator two-wire command port
`timescale 1ns/1ns
module test_oscillator_serial_command_port;
  // commit time kept short but longer than one address byte
  localparam int NvCyc = 200;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        powerDown = 1'b0;
  logic        sclIn;
  logic        sdaPull;
  logic        sdaOut;
  logic        sdaOe;
  logic        nvWriteBusy;
  logic        nvCommitPulse;
  logic        gotStrobe;
  logic [7:0]  gotByte;
  logic [7:0]  addressConfig;
  logic [15:0] dividerSetting;
  logic [15:0] outputMuxSetting;
  logic [15:0] d;
  logic [15:0] e;
  logic [15:0] divExp;
  logic [7:0]  c;
  logic [7:0]  expQ[$];
  logic [2:0]  sel = 3'b000;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          commitCount = 0;
  int          cycles = 0;
  int          seed = 76;
  wire         sdaWire = ~(((sdaOe & ~sdaOut) === 1'b1) | sdaPull);
  oscillator_serial_command_port #(.NvWriteCycles(NvCyc)) oscillator_serial_command_port_inst (
    .clock(clock), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .powerDown(powerDown), .dividerSetting(dividerSetting),
    .outputMuxSetting(outputMuxSetting), .addressConfig(addressConfig),
    .nvWriteBusy(nvWriteBusy), .nvCommitPulse(nvCommitPulse));
  osc_bus_master osc_bus_master_inst (.clock(clock), .sdaWire(sdaWire), .sclOut(sclIn),
    .sdaPull(sdaPull), .gotStrobe(gotStrobe), .gotByte(gotByte));
  ////////////////////////////////////////
  always #4 clock = ~clock;
  task automatic end_sim;
    $display("fail_count %0d cmp_count %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_bus(input logic [7:0] got);
    cmp_count++;
    if (expQ.size() == 0 || got !== expQ[0]) begin
      fail_count++;
      $display("wrong value at %0t: bus byte %h", $time, got);
    end
    if (expQ.size() > 0) void'(expQ.pop_front());
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (nvCommitPulse === 1'b1) commitCount++;
    if (gotStrobe === 1'b1) cmp_bus(gotByte);
    if (cycles == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  function automatic logic [7:0] me(input logic rw);
    return {osc_cmd_pkg::TYPE_CODE, sel, rw};
  endfunction
  task automatic wb(input logic [7:0] b, input logic [7:0] x);
    expQ.push_back(x);
    osc_bus_master_inst.wbyte(b);
  endtask
  // a refused address ends the frame at once
  task automatic wr(input logic [7:0] a, input logic ok, input logic [7:0] cm, input int n);
    osc_bus_master_inst.start(1'b0);
    wb(a, {7'h00, ~ok});
    for (int i = -1; ok && i < n; i++) wb(i < 0 ? cm : (i == 0 ? d[15:8] : d[7:0]), 8'h00);
    osc_bus_master_inst.stop();
  endtask
  task automatic rd(input logic [7:0] cm, input int n);
    osc_bus_master_inst.start(1'b0);
    wb(me(1'b0), 8'h00);
    wb(cm, 8'h00);
    osc_bus_master_inst.start(1'b1);
    wb(me(1'b1), 8'h00);
    for (int i = 0; i < n; i++) begin
      expQ.push_back(i == 0 ? e[15:8] : e[7:0]);
      osc_bus_master_inst.rbyte(i == n - 1);
    end
    osc_bus_master_inst.stop();
  endtask
  task automatic waitIdle;
    for (int i = 0; i < 1000 && nvWriteBusy !== 1'b0; i++) @(posedge clock);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    cmp_reg(dividerSetting | outputMuxSetting | addressConfig, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      c = k ? osc_cmd_pkg::CMD_MUX : osc_cmd_pkg::CMD_DIVIDER;
      d = 16'($random(seed));
      e = k ? d : (d & 16'hFFC0);
      if (k == 0) divExp = e;
      wr(me(1'b0), 1'b1, c, 2);
      cmp_reg({15'h0000, nvWriteBusy}, 16'h0001);
      wr(me(1'b0), 1'b0, c, 0);
      waitIdle();
      rd(c, 2);
      cmp_reg(k ? outputMuxSetting : dividerSetting, e);
    end
    wr({osc_cmd_pkg::TYPE_CODE, 3'b100, 1'b0}, 1'b0, c, 0);
    wr({~osc_cmd_pkg::TYPE_CODE, 3'b000, 1'b0}, 1'b0, c, 0);
    wr(me(1'b0), 1'b1, 8'h55, 2);
    cmp_reg(outputMuxSetting, e);
    cmp_reg(16'(commitCount), 16'h0002);
    d = 16'h0D00;
    wr(me(1'b0), 1'b1, osc_cmd_pkg::CMD_ADDR_CFG, 1);
    cmp_reg({15'h0000, nvWriteBusy}, 16'h0001);
    sel = 3'b101;
    waitIdle();
    e = 16'h0D00;
    rd(osc_cmd_pkg::CMD_ADDR_CFG, 1);
    d = 16'($random(seed));
    wr(me(1'b0), 1'b1, osc_cmd_pkg::CMD_MUX, 2);
    cmp_reg(16'(commitCount), 16'h0003);
    wr(me(1'b0), 1'b1, osc_cmd_pkg::CMD_COMMIT_NV, 0);
    cmp_reg({15'h0000, nvWriteBusy}, 16'h0001);
    cmp_reg(16'(commitCount), 16'h0004);
    waitIdle();
    d = ~divExp;
    powerDown <= 1'b1;
    wr(me(1'b0), 1'b1, osc_cmd_pkg::CMD_DIVIDER, 2);
    cmp_reg(dividerSetting, divExp);
    wr(me(1'b0), 1'b1, osc_cmd_pkg::CMD_COMMIT_NV, 0);
    cmp_reg(16'(commitCount), 16'h0004);
    end_sim();
  end
endmodule // test_oscillator_serial_command_port
